// File: verilog/sync_serial_channel.v
/*
 * Synchronous serial channel: master or slave shift engine with baud rate
 * generator, transmit and receive buffers, error detection and interrupts,
 * reached over a classic Wishbone slave.
 * Assumes all inputs, including the slave shift clock, are synchronous to clk_i.
 */
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "sync_serial_channel_consts.vh"

// Behaviour
// - Master drives shift clock; slave follows external.
// - Character length programmable from 2 to 16.
// - Selectable LSB-first or MSB-first shifting.
// - Selectable clock idle level, both modes.
// - Phase selects shift edge; latch opposite edge.
// - Full-duplex or half-duplex on shared line.
// - Separate transmit, receive and error interrupts.
// - Tx empty and rx full raise interrupts.
// - Buffer mishandling flags transmit/receive errors.
// - Phase and baudrate errors raise error interrupt.
// - Baud generator divides clock by 2(n+1).
// - Loopback option for testing.
// - Three link signals; configurable pin assignment.
module sync_serial_channel (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  input  wire        sclk_i,
  output reg         sclk_o,
  output reg         sclk_oe_o,
  input  wire        dpa_i,
  output reg         dpa_o,
  output reg         dpa_oe_o,
  input  wire        dpb_i,
  output reg         dpb_o,
  output reg         dpb_oe_o,
  output reg         irq_tx_o,
  output reg         irq_rx_o,
  output reg         irq_err_o,
  output reg         irq_o
);

  // --------------------------------------------------------------------------
  // Registers and state
  // --------------------------------------------------------------------------
  reg  [11:0] ctrl_ff;
  reg  [15:0] baud_ff;
  reg  [5:0]  ien_ff;
  reg  [5:0]  stat_ff;
  reg  [15:0] tb_ff;
  reg         tb_full_ff;
  reg  [15:0] rb_ff;
  reg         rb_full_ff;
  reg         busy_ff;
  reg         sclk_ff;
  reg  [15:0] brc_ff;
  reg  [5:0]  ecnt_ff;
  reg  [4:0]  rcnt_ff;
  reg  [15:0] tsh_ff;
  reg  [15:0] rsh_ff;
  reg         first_ff;
  reg         sprev_ff;
  reg         dprev_ff;
  reg  [15:0] gap_ff;

  wire [31:0] wmask;
  wire        acc;
  wire        wr;
  wire        rd;
  wire        en;
  wire        master;
  wire        cpol;
  wire        cpha;
  wire        msb;
  wire        hdx;
  wire        loopb;
  wire        tx_on_a;
  wire [3:0]  len_m1;
  wire [4:0]  len;
  wire        txbit;
  wire        pin_rx;
  wire        rxbit;
  wire        edge_ev;
  wire        lead;
  wire        latch_ev;
  wire        shift_ev;
  wire        last_latch;
  wire        start;
  wire        idle_clk;
  wire        rb_read;
  wire        tb_write;
  wire [15:0] rx_word;
  wire [15:0] rx_next;
  wire [5:0]  ev;
  wire [5:0]  clr;

  // --------------------------------------------------------------------------
  // Byte lane mask
  // --------------------------------------------------------------------------
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign wmask[lane*8 +: 8] = {8{sel_i[lane]}};
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Control decode
  // --------------------------------------------------------------------------
  assign acc     = cyc_i & stb_i & ack_o;
  assign wr      = acc & we_i;
  assign rd      = acc & ~we_i;
  assign en      = ctrl_ff[`CTRL_EN];
  assign master  = ctrl_ff[`CTRL_MASTER];
  assign cpol    = ctrl_ff[`CTRL_CPOL];
  assign cpha    = ctrl_ff[`CTRL_CPHA];
  assign msb     = ctrl_ff[`CTRL_MSB];
  assign hdx     = ctrl_ff[`CTRL_HDX];
  assign loopb   = ctrl_ff[`CTRL_LOOP];
  assign tx_on_a = master ^ ctrl_ff[`CTRL_SWAP];
  assign len_m1  = (ctrl_ff[`CTRL_LEN_HI:`CTRL_LEN_LO] == 4'h0) ? 4'h1 :
                   ctrl_ff[`CTRL_LEN_HI:`CTRL_LEN_LO];
  assign len     = {1'b0, len_m1} + 5'h01;
  assign txbit   = msb ? tsh_ff[len_m1] : tsh_ff[0];
  assign pin_rx  = (tx_on_a ^ hdx) ? dpb_i : dpa_i;
  assign rxbit   = loopb ? txbit : pin_rx;

  // --------------------------------------------------------------------------
  // Clock edges
  // --------------------------------------------------------------------------
  // master or slave edges
  assign idle_clk = master ? sclk_ff : sprev_ff;
  assign edge_ev  = master ? (busy_ff & (brc_ff == 16'h0000)) : (en & (sclk_i != sprev_ff));
  assign lead     = (idle_clk == cpol);
  assign latch_ev = busy_ff & edge_ev & (lead == cpha);
  assign shift_ev = busy_ff & edge_ev & (lead != cpha);
  assign last_latch = latch_ev & (rcnt_ff == len_m1 + 5'h00);
  assign start    = en & ~busy_ff & tb_full_ff & (master | ~edge_ev);
  assign rb_read  = rd & (adr_i == `OFS_RXDATA);
  assign tb_write = wr & (adr_i == `OFS_TXDATA);
  assign rx_next  = msb ? {rsh_ff[14:0], rxbit} : {rxbit, rsh_ff[15:1]};
  assign rx_word  = msb ? (rx_next & ((16'h0001 << len) - 16'h0001)) :
                          (rx_next >> (5'h10 - len));

  // --------------------------------------------------------------------------
  // Events
  // --------------------------------------------------------------------------
  // buffer empty and full
  assign ev[`EV_TX_EMPTY] = start;
  assign ev[`EV_RX_FULL]  = last_latch;
  assign ev[`EV_TX_ERR]   = (tb_write & tb_full_ff) | (en & ~master & ~busy_ff & edge_ev);
  assign ev[`EV_RX_ERR]   = last_latch & rb_full_ff & ~rb_read;
  assign ev[`EV_PH_ERR]   = ~master & latch_ev & (pin_rx != dprev_ff) & ~loopb;
  assign ev[`EV_BR_ERR]   = ~master & busy_ff & edge_ev & (gap_ff < baud_ff);
  assign clr = (wr & (adr_i == `OFS_IRQ_CLR)) ? dat_i[5:0] & wmask[5:0] : 6'h00;

  // --------------------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o   <= 1'b0;
      dat_o   <= 32'h00000000;
      ctrl_ff <= `RST_CTRL;
      baud_ff <= `RST_BAUD;
      ien_ff  <= `RST_IRQ_EN;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      case (adr_i)
        `OFS_CTRL:   dat_o <= {20'h00000, ctrl_ff};
        `OFS_BAUD:   dat_o <= {16'h0000, baud_ff};
        `OFS_TXDATA: dat_o <= {16'h0000, tb_ff};
        `OFS_RXDATA: dat_o <= {16'h0000, rb_ff};
        `OFS_STATUS: dat_o <= {21'h000000, rb_full_ff, tb_full_ff, busy_ff, 2'b00, stat_ff};
        `OFS_IRQ_EN: dat_o <= {26'h0000000, ien_ff};
        default:     dat_o <= 32'h00000000;
      endcase
      if (wr && (adr_i == `OFS_CTRL)) begin
        ctrl_ff <= (ctrl_ff & ~wmask[11:0]) | (dat_i[11:0] & wmask[11:0]);
      end
      if (wr && (adr_i == `OFS_BAUD)) begin
        baud_ff <= (baud_ff & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
      end
      if (wr && (adr_i == `OFS_IRQ_EN)) begin
        ien_ff <= (ien_ff & ~wmask[5:0]) | (dat_i[5:0] & wmask[5:0]);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Buffers and sticky status
  // --------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      tb_ff      <= 16'h0000;
      tb_full_ff <= 1'b0;
      rb_ff      <= 16'h0000;
      rb_full_ff <= 1'b0;
      stat_ff    <= 6'h00;
    end else begin
      if (tb_write) begin
        tb_ff      <= (tb_ff & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
        tb_full_ff <= 1'b1;
      end else if (start) begin
        tb_full_ff <= 1'b0;
      end
      if (last_latch) begin
        rb_ff      <= rx_word;
        rb_full_ff <= 1'b1;
      end else if (rb_read) begin
        rb_full_ff <= 1'b0;
      end
      stat_ff <= (stat_ff & ~clr) | ev;
    end
  end

  // --------------------------------------------------------------------------
  // Shift engine
  // --------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff  <= 1'b0;
      sclk_ff  <= 1'b0;
      brc_ff   <= 16'h0000;
      ecnt_ff  <= 6'h00;
      rcnt_ff  <= 5'h00;
      tsh_ff   <= 16'h0000;
      rsh_ff   <= 16'h0000;
      first_ff <= 1'b0;
      sprev_ff <= 1'b0;
      dprev_ff <= 1'b0;
      gap_ff   <= 16'h0000;
    end else begin
      sprev_ff <= sclk_i;
      dprev_ff <= pin_rx;
      if (edge_ev) begin
        gap_ff <= 16'h0000;
      end else if (gap_ff != 16'hffff) begin
        gap_ff <= gap_ff + 16'h0001;
      end
      if (!en) begin
        busy_ff <= 1'b0;
        sclk_ff <= cpol;
      end else if (start) begin
        busy_ff  <= 1'b1;
        tsh_ff   <= tb_ff;
        brc_ff   <= baud_ff;
        ecnt_ff  <= 6'h00;
        rcnt_ff  <= 5'h00;
        first_ff <= 1'b1;
        sclk_ff  <= cpol;
      end else if (busy_ff) begin
        if (master) begin
          if (brc_ff == 16'h0000) begin
            brc_ff  <= baud_ff;
            sclk_ff <= ~sclk_ff;
          end else begin
            brc_ff <= brc_ff - 16'h0001;
          end
        end
        if (edge_ev) begin
          first_ff <= 1'b0;
          ecnt_ff  <= ecnt_ff + 6'h01;
        end
        if (shift_ev && !(first_ff && !cpha)) begin
          tsh_ff <= msb ? {tsh_ff[14:0], 1'b0} : {1'b0, tsh_ff[15:1]};
        end
        if (latch_ev) begin
          rsh_ff  <= rx_next;
          rcnt_ff <= rcnt_ff + 5'h01;
        end
        if (edge_ev && (ecnt_ff == {len, 1'b0} - 6'h01)) begin
          busy_ff <= 1'b0;
        end
      end else begin
        sclk_ff <= cpol;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pins and interrupt outputs
  // --------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      sclk_o    <= 1'b0;
      sclk_oe_o <= 1'b0;
      dpa_o     <= 1'b0;
      dpa_oe_o  <= 1'b0;
      dpb_o     <= 1'b0;
      dpb_oe_o  <= 1'b0;
      irq_tx_o  <= 1'b0;
      irq_rx_o  <= 1'b0;
      irq_err_o <= 1'b0;
      irq_o     <= 1'b0;
    end else begin
      sclk_o    <= sclk_ff;
      sclk_oe_o <= en & master;
      dpa_o    <= tx_on_a & ~hdx & txbit;
      dpa_oe_o <= en & ~loopb & tx_on_a & (~hdx | (busy_ff & ~txbit));
      dpb_o    <= ~tx_on_a & ~hdx & txbit;
      dpb_oe_o <= en & ~loopb & ~tx_on_a & (~hdx | (busy_ff & ~txbit));
      irq_tx_o  <= stat_ff[`EV_TX_EMPTY] & ien_ff[`EV_TX_EMPTY];
      irq_rx_o  <= stat_ff[`EV_RX_FULL] & ien_ff[`EV_RX_FULL];
      irq_err_o <= |(stat_ff[5:2] & ien_ff[5:2]);
      irq_o     <= |(stat_ff & ien_ff);
    end
  end

endmodule
`default_nettype wire

// File: verilog/sync_serial_channel_consts.vh
/*
 * Constants of the synchronous serial channel: register offsets, field positions
 * and reset values.
 * Assumes a Wishbone slave with 32-bit data and byte addresses.
 */
`ifndef SYNC_SERIAL_CHANNEL_CONSTS_VH
`define SYNC_SERIAL_CHANNEL_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_BAUD      8'h04
`define OFS_TXDATA    8'h08
`define OFS_RXDATA    8'h0c
`define OFS_STATUS    8'h10
`define OFS_IRQ_CLR   8'h14
`define OFS_IRQ_EN    8'h18

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTRL_LEN_LO   0
`define CTRL_LEN_HI   3
`define CTRL_MSB      4
`define CTRL_CPOL     5
`define CTRL_CPHA     6
`define CTRL_MASTER   7
`define CTRL_EN       8
`define CTRL_HDX      9
`define CTRL_LOOP     10
`define CTRL_SWAP     11
`define CTRL_WIDTH    12

// ----------------------------------------------------------------------------
// Event bits of status, clear and enable registers; busy and buffer full flags of status
// ----------------------------------------------------------------------------
`define EV_TX_EMPTY   0
`define EV_RX_FULL    1
`define EV_TX_ERR     2
`define EV_RX_ERR     3
`define EV_PH_ERR     4
`define EV_BR_ERR     5
`define EV_WIDTH      6
`define ST_BUSY       8
`define ST_TB_FULL    9
`define ST_RB_FULL    10

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_CTRL      12'h00f
`define RST_BAUD      16'h0000
`define RST_IRQ_EN    6'h00

`endif

// File: verif/ssc_chk.sv
/* Checker of the channel's bus, interrupt and pin-enable ports.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/10ps
`default_nettype none
module ssc_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        sclk_oe_o,
  input wire logic        dpa_oe_o,
  input wire logic        dpb_oe_o,
  input wire logic        irq_tx_o,
  input wire logic        irq_rx_o,
  input wire logic        irq_err_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held for more than one cycle");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in one cycle");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  a_unmapped_zero: assert property (ack_o && !$past(we_i) && $past(adr_i) > 8'h18
    |-> dat_o == 32'h0) else $error("unmapped read not zero");
  a_irq_any: assert property (irq_o == (irq_tx_o || irq_rx_o || irq_err_o))
    else $error("summary interrupt differs from sources");
  a_err_sticky: assert property (irq_err_o && !(cyc_i && we_i)
    && !$past(cyc_i && we_i) |=> irq_err_o) else $error("error interrupt dropped");
  a_pins_apart: assert property (!(dpa_oe_o && dpb_oe_o))
    else $error("both data pins driven");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i
    |=> !ack_o && !irq_o && !sclk_oe_o) else $error("outputs active after reset");
  c_rx: cover property ($rose(irq_rx_o));
  c_err: cover property ($rose(irq_err_o));
  c_master: cover property ($rose(sclk_oe_o));
endmodule
`default_nettype wire

// File: verif/spi_peer.sv
/* Peer at the far end of the link: a shift-register slave on the master clock.
   Assumes it is cleared before each character. */
`timescale 1ns/10ps
`default_nettype none
module spi_peer (
  input  wire logic        clk_i,
  input  wire logic        clr_i,
  input  wire logic        sclk_i,
  input  wire logic        mosi_i,
  input  wire logic        cpol_i,
  input  wire logic        cpha_i,
  input  wire logic        msb_i,
  input  wire logic [4:0]  len_i,
  input  wire logic [15:0] tx_i,
  output var  logic        miso_o = 1'b0,
  output var  logic [15:0] rx_o
);
  logic prev = 1'b0;
  int   sc = 0;
  int   lc = 0;
  function automatic int pos(int k);
    return msb_i ? len_i - 1 - k : k;
  endfunction
  always @(posedge clk_i) begin
    if (clr_i) begin
      prev <= sclk_i;
      sc <= cpha_i;
      lc <= 0;
      rx_o <= 16'h0;
      miso_o <= tx_i[pos(0)];
    end else if (sclk_i !== prev) begin
      prev <= sclk_i;
      if ((sclk_i != cpol_i) != cpha_i) begin
        sc <= sc + 1;
        if (sc < len_i) miso_o <= tx_i[pos(sc)];
      end else if (lc < len_i) begin
        rx_o[pos(lc)] <= mosi_i;
        lc <= lc + 1;
      end
    end else if (lc >= len_i) miso_o <= ~miso_o;
  end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
/* Self-checking bench: random master transfers against the peer, loopback,
   interrupts and error flags. Assumes the design header on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "sync_serial_channel_consts.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sclk = 0, clr = 0;
  logic pol = 0, pha = 0, msbf = 0, lp, miso;
  logic [4:0] len = 5'd16;
  logic [7:0] adr = 0;
  logic [15:0] ptx = 0, prx, d16, pt;
  logic [31:0] wd = 0, q, r, seed = 45;
  logic [31:0] dat_o;
  logic ack_o, sclk_o, sclk_oe_o, dpa_o, dpa_oe_o, dpb_o, dpb_oe_o;
  logic irq_tx_o, irq_rx_o, irq_err_o, irq_o;
  int n_errors = 0, n_checks = 0, ln;
  logic [7:0] ra[5] = '{`OFS_CTRL, `OFS_BAUD, `OFS_IRQ_EN, `OFS_STATUS, 8'h40};
  logic [31:0] rv[5] = '{32'h00f, 32'h0, 32'h0, 32'h0, 32'h0};
  wire logic dpa = dpa_oe_o ? dpa_o : 1'b1;
  wire logic dpb = dpb_oe_o ? dpb_o : miso;
  sync_serial_channel dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wd), .dat_o(dat_o), .ack_o(ack_o),
    .sclk_i(sclk), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .dpa_i(dpa), .dpa_o(dpa_o),
    .dpa_oe_o(dpa_oe_o), .dpb_i(dpb), .dpb_o(dpb_o), .dpb_oe_o(dpb_oe_o),
    .irq_tx_o(irq_tx_o), .irq_rx_o(irq_rx_o), .irq_err_o(irq_err_o), .irq_o(irq_o));
  spi_peer peer (.clk_i(clk_i), .clr_i(clr), .sclk_i(sclk_o), .mosi_i(dpa), .cpol_i(pol),
    .cpha_i(pha), .msb_i(msbf), .len_i(len), .tx_i(ptx), .miso_o(miso), .rx_o(prx));
  initial forever #50 clk_i = ~clk_i;
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] msk(int n);
    logic [16:0] t;
    t = (17'h1 << n) - 17'h1;
    return t[15:0];
  endfunction
  task print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin @(posedge clk_i); k++; end while (ack_o !== 1'b1 && k < 20);
    if (k >= 20) begin n_errors++; print_verdict(); end
    q = dat_o;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic xfer(input logic [15:0] d);
    int k;
    k = 0;
    bus(1, `OFS_TXDATA, {16'h0, d});
    do begin bus(0, `OFS_STATUS, 0); k++; end
      while ((q[`EV_RX_FULL] !== 1'b1 || q[`ST_BUSY] !== 1'b0) && k < 300);
    if (k >= 300) begin n_errors++; print_verdict(); end
    tick(2);
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 0; i < 5; i++) begin
      bus(0, ra[i], 0);
      `CHK(q, rv[i])
    end
    bus(1, `OFS_IRQ_EN, 32'h3f);
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      ln = (i == 0) ? 2 : (i == 1) ? 16 : 2 + r % 15;
      lp = (i % 4 == 3);
      q = rnd();
      d16 = q[15:0] & msk(ln);
      pt = q[31:16] & msk(ln);
      bus(1, `OFS_BAUD, {30'h0, r[13:12]} + 32'd2);
      bus(1, `OFS_CTRL, {21'h0, lp, 3'b011, r[10], r[9], r[8], 4'(ln - 1)});
      pol <= r[9];
      pha <= r[10];
      msbf <= r[8];
      len <= 5'(ln);
      ptx <= pt;
      repeat (3) @(posedge clk_i);
      clr <= 1;
      @(posedge clk_i);
      clr <= 0;
      xfer(d16);
      `CHK(sclk_o, r[9])
      `CHK(dpa_oe_o, !lp)
      if (!lp) `CHK(prx, d16)
      `CHK(irq_tx_o, 1'b1)
      `CHK(irq_rx_o, 1'b1)
      bus(0, `OFS_RXDATA, 0);
      `CHK(q, {16'h0, lp ? d16 : pt})
      bus(1, `OFS_IRQ_CLR, 32'h3f);
    end
    xfer(16'h0005);
    xfer(16'h000a);
    tick(2);
    `CHK(irq_err_o, 1'b1)
    tick(10);
    `CHK(irq_err_o, 1'b1)
    bus(0, `OFS_STATUS, 0);
    `CHK(q[`EV_RX_ERR], 1'b1)
    bus(1, `OFS_IRQ_EN, 32'h0);
    tick(2);
    `CHK(irq_o, 1'b0)
    bus(1, `OFS_IRQ_EN, 32'h3f);
    bus(1, `OFS_IRQ_CLR, 32'h3f);
    tick(2);
    `CHK(irq_err_o, 1'b0)
    bus(1, `OFS_CTRL, 32'h10f);
    bus(1, `OFS_IRQ_CLR, 32'h3f);
    repeat (4) begin
      repeat (8) @(posedge clk_i);
      sclk <= ~sclk;
    end
    tick(3);
    `CHK(irq_err_o, 1'b1)
    bus(0, `OFS_STATUS, 0);
    `CHK(q[`EV_TX_ERR], 1'b1)
    bus(1, `OFS_IRQ_CLR, 32'h3f);
    bus(1, `OFS_TXDATA, 32'h1234);
    repeat (4) begin
      @(posedge clk_i);
      sclk <= ~sclk;
    end
    tick(3);
    bus(0, `OFS_STATUS, 0);
    `CHK(q[`EV_BR_ERR], 1'b1)
    `CHK({dpa_oe_o, dpb_oe_o}, 2'b01)
    bus(1, `OFS_CTRL, 32'h00f);
    bus(1, `OFS_CTRL, 32'h90f);
    tick(2);
    `CHK({dpa_oe_o, dpb_oe_o}, 2'b10)
    bus(1, `OFS_CTRL, 32'h30f);
    tick(2);
    `CHK({dpb_o, dpb_oe_o}, 2'b00)
    print_verdict();
  end
endmodule
bind sync_serial_channel ssc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .sclk_oe_o(sclk_oe_o), .dpa_oe_o(dpa_oe_o), .dpb_oe_o(dpb_oe_o), .irq_tx_o(irq_tx_o),
  .irq_rx_o(irq_rx_o), .irq_err_o(irq_err_o), .irq_o(irq_o));
`default_nettype wire
